// ### hw/omc_pkg.sv
// constants and types of the operating mode controller
package omc_pkg;
	// register port offsets (byte addresses)
	localparam logic [7:0] OSC_MODE_ADDR = 8'h00;
	localparam logic [7:0] WAKE_EN_ADDR  = 8'h04;
	localparam logic [7:0] STATUS_ADDR   = 8'h08;
	// oscillator mode register fields
	localparam int CPU_SLEEP_BIT  = 0;
	localparam int CPU_GREEN_BIT  = 1;
	localparam int STOP_HIGH_BIT  = 2;
	localparam int CLK_MODE_BIT   = 3;
	// reset values
	localparam logic [3:0] OSC_MODE_RST = 4'h0;
	localparam logic [3:0] WAKE_EN_RST  = 4'h0;
	// port widths
	localparam int PORT0_W = 8;
	localparam int PORT1_W = 4;
	// oscillator settle count after power down wake, in high clocks
	localparam int SETTLE_CLKS = 2048;
	localparam int CNT_W       = 12;
	// slow mode divider of the low clock
	localparam int SLOW_DIV = 4;
	// mode encodings, one-hot
	typedef enum logic [5:0] {
		OMC_NORMAL = 6'h01,
		OMC_SLOW   = 6'h02,
		OMC_SLEEP  = 6'h04,
		OMC_HALT   = 6'h08,
		OMC_GREEN  = 6'h10,
		OMC_SETTLE = 6'h20
	} omc_mode_e;
endpackage

// ### hw/omc_wake_det.sv
// level change detector for a group of wake pins
`timescale 1ns/1ns
`default_nettype none
module omc_wake_det #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	// pins and control
	input  wire logic [W-1:0] pins,
	input  wire logic [W-1:0] enable,
	input  wire logic         capture,
	// result
	output logic              changed
);
	logic [W-1:0] sync1_ff;
	logic [W-1:0] sync2_ff;
	logic [W-1:0] ref_ff;

	// two stage synchroniser
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else if (clk_en) begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
		end
	end

	// reference level taken on entry to low power
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ref_ff <= '0;
		end else if (clk_en && capture) begin
			ref_ff <= sync2_ff;
		end
	end

	assign changed = |((sync2_ff ^ ref_ff) & enable);
endmodule
`default_nettype wire

// ### hw/omc_top.sv
// operating mode controller: mode state machine, control register, wake logic
`timescale 1ns/1ns
`default_nettype none
module omc_top (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire logic                          clk_en,
	// register port
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	// wake sources
	input  wire logic [omc_pkg::PORT0_W-1:0]   port_zero,
	input  wire logic [omc_pkg::PORT1_W-1:0]   port_one,
	input  wire logic                          wake_timer_ovf,
	input  wire logic                          wake_timer_en,
	// low clock tick, one cycle per low oscillator period
	input  wire logic                          low_clk_tick,
	// clock and core control
	output logic                               high_osc_on,
	output logic                               low_osc_on,
	output logic                               sys_clk_low_sel,
	output logic                               cpu_run,
	output logic                               cpu_clk_en,
	output logic                               wake_timer_run
);
	omc_pkg::omc_mode_e             mode_ff;
	omc_pkg::omc_mode_e             nxt_mode;
	logic [3:0]                     osc_mode_ff;
	logic [omc_pkg::PORT1_W-1:0]    wake_en_ff;
	logic [omc_pkg::CNT_W-1:0]      settle_ff;
	logic [1:0]                     div_ff;
	logic                           green_from_slow_ff;
	logic [7:0]                     reg_rdata_ff;
	logic                           p0_change;
	logic                           p1_change;
	logic                           pin_wake;
	logic                           capture;
	logic                           wr_osc;
	logic                           stop_high;
	logic                           settle_done;

	localparam logic [omc_pkg::CNT_W-1:0] SETTLE_LAST = omc_pkg::CNT_W'(omc_pkg::SETTLE_CLKS - 1);
	localparam logic [1:0]                DIV_LAST    = 2'(omc_pkg::SLOW_DIV - 1);

	assign wr_osc    = reg_wr && (reg_addr == omc_pkg::OSC_MODE_ADDR);
	assign stop_high = osc_mode_ff[omc_pkg::STOP_HIGH_BIT];
	assign capture   = (mode_ff == omc_pkg::OMC_NORMAL) || (mode_ff == omc_pkg::OMC_SLOW);

	omc_wake_det #(.W(omc_pkg::PORT0_W)) u_det0 (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.pins     (port_zero),
		.enable   ({omc_pkg::PORT0_W{1'b1}}),
		.capture  (capture),
		.changed  (p0_change)
	);

	omc_wake_det #(.W(omc_pkg::PORT1_W)) u_det1 (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.pins     (port_one),
		.enable   (wake_en_ff),
		.capture  (capture),
		.changed  (p1_change)
	);

	assign pin_wake    = p0_change || p1_change;
	assign settle_done = (settle_ff == SETTLE_LAST);

	// mode state machine
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			omc_pkg::OMC_NORMAL: begin
				if (wr_osc && reg_wdata[omc_pkg::CPU_SLEEP_BIT])
					nxt_mode = omc_pkg::OMC_SLEEP;
				else if (wr_osc && reg_wdata[omc_pkg::CPU_GREEN_BIT])
					nxt_mode = omc_pkg::OMC_GREEN;
				else if (wr_osc && reg_wdata[omc_pkg::STOP_HIGH_BIT] && !reg_wdata[omc_pkg::CLK_MODE_BIT])
					nxt_mode = omc_pkg::OMC_HALT;
				else if (wr_osc && reg_wdata[omc_pkg::CLK_MODE_BIT])
					nxt_mode = omc_pkg::OMC_SLOW;
			end
			omc_pkg::OMC_SLOW: begin
				if (wr_osc && reg_wdata[omc_pkg::CPU_SLEEP_BIT])
					nxt_mode = omc_pkg::OMC_SLEEP;
				else if (wr_osc && reg_wdata[omc_pkg::CPU_GREEN_BIT])
					nxt_mode = omc_pkg::OMC_GREEN;
				// clock mode 0 back to normal, or to halt with stop high set; software keeps order
				else if (wr_osc && !reg_wdata[omc_pkg::CLK_MODE_BIT])
					nxt_mode = reg_wdata[omc_pkg::STOP_HIGH_BIT] ? omc_pkg::OMC_HALT : omc_pkg::OMC_NORMAL;
			end
			// power down wake by pins only
			omc_pkg::OMC_SLEEP, omc_pkg::OMC_HALT: begin
				if (pin_wake)
					nxt_mode = omc_pkg::OMC_SETTLE;
			end
			omc_pkg::OMC_GREEN: begin
				// pins or enabled timer, no delay
				if (pin_wake || (wake_timer_en && wake_timer_ovf))
					nxt_mode = green_from_slow_ff ? omc_pkg::OMC_SLOW : omc_pkg::OMC_NORMAL;
			end
			omc_pkg::OMC_SETTLE: begin
				if (settle_done)
					nxt_mode = omc_pkg::OMC_NORMAL;
			end
			default: nxt_mode = omc_pkg::OMC_NORMAL;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			mode_ff <= omc_pkg::OMC_NORMAL;
		else if (clk_en)
			mode_ff <= nxt_mode;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			green_from_slow_ff <= 1'b0;
		else if (clk_en && nxt_mode == omc_pkg::OMC_GREEN && mode_ff != omc_pkg::OMC_GREEN)
			green_from_slow_ff <= (mode_ff == omc_pkg::OMC_SLOW);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			settle_ff <= '0;
		else if (clk_en) begin
			if (mode_ff == omc_pkg::OMC_SETTLE)
				settle_ff <= settle_ff + 1'b1;
			else
				settle_ff <= '0;
		end
	end

	// oscillator mode register with hardware clears
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			osc_mode_ff <= omc_pkg::OSC_MODE_RST;
		else if (clk_en) begin
			// clear sleep on power down wake
			if ((mode_ff == omc_pkg::OMC_SLEEP || mode_ff == omc_pkg::OMC_HALT) && pin_wake) begin
				osc_mode_ff[omc_pkg::CPU_SLEEP_BIT] <= 1'b0;
				osc_mode_ff[omc_pkg::STOP_HIGH_BIT] <= 1'b0;
				osc_mode_ff[omc_pkg::CLK_MODE_BIT]  <= 1'b0;
			end
			if (mode_ff == omc_pkg::OMC_GREEN && nxt_mode != omc_pkg::OMC_GREEN)
				osc_mode_ff[omc_pkg::CPU_GREEN_BIT] <= 1'b0;
			// a software write in the same cycle as a wake clear wins
			if (wr_osc)
				osc_mode_ff <= reg_wdata[3:0];
		end
	end

	// port 1 wake enables
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			wake_en_ff <= omc_pkg::WAKE_EN_RST;
		else if (clk_en && reg_wr && reg_addr == omc_pkg::WAKE_EN_ADDR)
			wake_en_ff <= reg_wdata[omc_pkg::PORT1_W-1:0];
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			reg_rdata_ff <= '0;
		else if (clk_en) begin
			if (!reg_rd)
				reg_rdata_ff <= '0;
			else if (reg_addr == omc_pkg::OSC_MODE_ADDR)
				reg_rdata_ff <= {4'h0, osc_mode_ff};
			else if (reg_addr == omc_pkg::WAKE_EN_ADDR)
				reg_rdata_ff <= {4'h0, wake_en_ff};
			else if (reg_addr == omc_pkg::STATUS_ADDR)
				reg_rdata_ff <= {2'h0, mode_ff};
			else
				reg_rdata_ff <= '0;
		end
	end
	assign reg_rdata = reg_rdata_ff;

	// slow mode divider of the low clock tick
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			div_ff <= '0;
		else if (clk_en) begin
			if (mode_ff != omc_pkg::OMC_SLOW)
				div_ff <= '0;
			else if (low_clk_tick)
				div_ff <= (div_ff == DIV_LAST) ? 2'h0 : div_ff + 2'h1;
		end
	end

	assign high_osc_on = (mode_ff == omc_pkg::OMC_NORMAL) || (mode_ff == omc_pkg::OMC_SETTLE)
		|| ((mode_ff == omc_pkg::OMC_SLOW || mode_ff == omc_pkg::OMC_GREEN) && !stop_high);
	assign low_osc_on  = !(mode_ff == omc_pkg::OMC_SLEEP || mode_ff == omc_pkg::OMC_HALT);
	assign sys_clk_low_sel = (mode_ff == omc_pkg::OMC_SLOW)
		|| (mode_ff == omc_pkg::OMC_GREEN && green_from_slow_ff);
	// core halted outside normal and slow
	assign cpu_run    = capture;
	assign cpu_clk_en = (mode_ff == omc_pkg::OMC_NORMAL)
		|| (mode_ff == omc_pkg::OMC_SLOW && low_clk_tick && div_ff == DIV_LAST);
	assign wake_timer_run = capture || (mode_ff == omc_pkg::OMC_GREEN);

	// assertion helpers
	logic [omc_pkg::CNT_W:0] settle_len_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			settle_len_ff <= '0;
		else if (clk_en)
			settle_len_ff <= (mode_ff == omc_pkg::OMC_SETTLE) ? settle_len_ff + 1'b1 : '0;
	end

	sequence s_green_wake;
		mode_ff == omc_pkg::OMC_GREEN && clk_en && (pin_wake || (wake_timer_en && wake_timer_ovf));
	endsequence

	AST_RESET_NORMAL: assert property (@(posedge core_clk) $fell(rst) |-> mode_ff == omc_pkg::OMC_NORMAL)
		else $error("mode not normal after reset");
	AST_SLEEP_ENTRY: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && wr_osc && reg_wdata[0] && capture |=> mode_ff == omc_pkg::OMC_SLEEP)
		else $error("sleep write did not enter power down");
	AST_SLEEP_OSC_OFF: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_SLEEP |-> !high_osc_on && !low_osc_on && !cpu_run)
		else $error("oscillator running in power down");
	AST_SLEEP_WAKE: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_SLEEP && clk_en && pin_wake
		|=> mode_ff == omc_pkg::OMC_SETTLE && !osc_mode_ff[0])
		else $error("power down wake wrong");
	AST_SETTLE_LEN: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_NORMAL && $past(mode_ff) == omc_pkg::OMC_SETTLE && $past(clk_en)
		|-> settle_len_ff == 13'(omc_pkg::SETTLE_CLKS))
		else $error("settle length wrong");
	AST_GREEN_RETURN: assert property (@(posedge core_clk) disable iff (rst)
		s_green_wake |=> mode_ff == (green_from_slow_ff ? omc_pkg::OMC_SLOW : omc_pkg::OMC_NORMAL)
		&& !osc_mode_ff[1])
		else $error("green wake returned to wrong mode");
	AST_GREEN_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_GREEN && clk_en && !pin_wake && !(wake_timer_en && wake_timer_ovf)
		|=> mode_ff == omc_pkg::OMC_GREEN)
		else $error("green left without wake source");
	AST_NORMAL_OSC: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_NORMAL |-> high_osc_on && low_osc_on && cpu_clk_en)
		else $error("normal mode oscillator off");
	AST_GREEN_CLK: assert property (@(posedge core_clk) disable iff (rst)
		mode_ff == omc_pkg::OMC_GREEN |-> !cpu_run && wake_timer_run && low_osc_on)
		else $error("green mode clocking wrong");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench of the operating mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic       core_clk;
	logic       rst;
	logic       clk_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] port_zero;
	logic [3:0] port_one;
	logic       wake_timer_ovf;
	logic       wake_timer_en;
	logic       low_clk_tick;
	logic       high_osc_on;
	logic       low_osc_on;
	logic       sys_clk_low_sel;
	logic       cpu_run;
	logic       cpu_clk_en;
	logic       wake_timer_run;
	logic [2:0] tick_div;
	logic [7:0] rd_val;
	int         fails;
	int         cmp_count;
	int         n_en;

	// device under test
	omc_top u_omc_top (
		.core_clk        (core_clk),
		.rst             (rst),
		.clk_en          (clk_en),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.port_zero       (port_zero),
		.port_one        (port_one),
		.wake_timer_ovf  (wake_timer_ovf),
		.wake_timer_en   (wake_timer_en),
		.low_clk_tick    (low_clk_tick),
		.high_osc_on     (high_osc_on),
		.low_osc_on      (low_osc_on),
		.sys_clk_low_sel (sys_clk_low_sel),
		.cpu_run         (cpu_run),
		.cpu_clk_en      (cpu_clk_en),
		.wake_timer_run  (wake_timer_run)
	);

	// 125 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// low oscillator tick, one every five core cycles
	always @(posedge core_clk) begin
		tick_div     <= (tick_div == 3'h4) ? 3'h0 : tick_div + 3'h1;
		low_clk_tick <= (tick_div == 3'h4);
	end

	// verdict and end of run
	task tally_and_finish;
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// compare and count
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// one-cycle register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// one-cycle register read, data taken in the following cycle
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(negedge core_clk);
		rd_val = reg_rdata;
	endtask

	// poll the status register for a mode, bounded by lim+1 reads
	task wait_mode(input logic [7:0] m, input int lim);
		int i;
		i = 0;
		rd(omc_pkg::STATUS_ADDR);
		while (rd_val !== m && i < lim) begin
			rd(omc_pkg::STATUS_ADDR);
			i++;
		end
		chk(rd_val, m, "mode wait");
	endtask

	// high, low, select, run outputs
	task outs(input logic [3:0] exp);
		@(negedge core_clk);
		chk({4'h0, high_osc_on, low_osc_on, sys_clk_low_sel, cpu_run}, {4'h0, exp}, "clock outputs");
	endtask

	// count core enables over a span
	task count_en(input int cyc);
		n_en = 0;
		repeat (cyc) begin
			@(negedge core_clk);
			n_en += int'(cpu_clk_en === 1'b1);
		end
	endtask

	// bound on a hung run
	initial begin
		#400000;
		fails++;
		tally_and_finish;
	end

	// main sequence
	initial begin
		fails = 0; cmp_count = 0; tick_div = 3'h0; low_clk_tick = 1'b0;
		rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; clk_en = 1'b1;
		port_zero = 8'h00; port_one = 4'h0; wake_timer_ovf = 1'b0; wake_timer_en = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h01, "reset mode");
		// a write while the clock enable is low must be lost
		clk_en <= 1'b0; wr(omc_pkg::OSC_MODE_ADDR, 8'h01); clk_en <= 1'b1;
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h01, "frozen write mode");
		rd(omc_pkg::OSC_MODE_ADDR); chk(rd_val, 8'h00, "frozen write reg");
		outs(4'b1101);
		count_en(20); chk(8'(n_en), 8'd20, "normal enable");
		rd(8'h0c); chk(rd_val, 8'h00, "unmapped read");
		wr(omc_pkg::WAKE_EN_ADDR, 8'h02); rd(omc_pkg::WAKE_EN_ADDR); chk(rd_val, 8'h02, "wake enable");
		wr(omc_pkg::OSC_MODE_ADDR, 8'h08); outs(4'b1111);
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h02, "slow mode");
		count_en(200); chk({7'h0, n_en >= 9 && n_en <= 11}, 8'h01, "slow divide");
		wr(omc_pkg::OSC_MODE_ADDR, 8'h0c); outs(4'b0111);
		wr(omc_pkg::OSC_MODE_ADDR, 8'h0e); rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h10, "green");
		chk({6'h0, cpu_run, wake_timer_run}, 8'h01, "green run");
		@(posedge core_clk); wake_timer_ovf <= 1'b1;
		@(posedge core_clk); wake_timer_ovf <= 1'b0;
		repeat (10) @(posedge core_clk);
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h10, "timer wake off");
		wake_timer_en <= 1'b1; wake_timer_ovf <= 1'b1;
		@(posedge core_clk); wake_timer_ovf <= 1'b0;
		wait_mode(8'h02, 4);
		rd(omc_pkg::OSC_MODE_ADDR); chk(rd_val, 8'h0c, "green cleared");
		wr(omc_pkg::OSC_MODE_ADDR, 8'h08); repeat (50) @(posedge core_clk);
		wr(omc_pkg::OSC_MODE_ADDR, 8'h00); outs(4'b1101);
		wr(omc_pkg::OSC_MODE_ADDR, 8'h08); wr(omc_pkg::OSC_MODE_ADDR, 8'h09);
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h04, "sleep");
		chk({5'h0, high_osc_on, low_osc_on, cpu_run}, 8'h00, "sleep outputs");
		@(posedge core_clk); port_one <= 4'h1;
		repeat (20) @(posedge core_clk);
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h04, "masked pin");
		@(posedge core_clk); port_zero <= 8'h01;
		wait_mode(8'h20, 8);
		repeat (2000) @(posedge core_clk);
		rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h20, "settling");
		wait_mode(8'h01, 40);
		rd(omc_pkg::OSC_MODE_ADDR); chk(rd_val, 8'h00, "sleep cleared");
		wr(omc_pkg::OSC_MODE_ADDR, 8'h02); rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h10, "green n");
		chk({6'h0, high_osc_on, low_osc_on}, 8'h03, "green clocks");
		@(posedge core_clk); port_one <= 4'h3;
		wait_mode(8'h01, 6);
		rd(omc_pkg::OSC_MODE_ADDR); chk(rd_val, 8'h00, "green n cleared");
		wr(omc_pkg::OSC_MODE_ADDR, 8'h04); rd(omc_pkg::STATUS_ADDR); chk(rd_val, 8'h08, "halt");
		@(posedge core_clk); port_zero <= 8'h00;
		wait_mode(8'h20, 8);
		wait_mode(8'h01, 1100);
		tally_and_finish;
	end
endmodule
`default_nettype wire
